/* hw/serdes_params.svh */
// Addresses, register offsets, field positions and timing counts
`ifndef SERDES_PARAMS_SVH
`define SERDES_PARAMS_SVH
`define DES1_ADDR7      7'h60
`define DES2_ADDR7      7'h30
`define SER_ADDR7       7'h58
`define SER_ID_VAL      8'hB0
`define IMG_ID_VAL      8'h90
`define REG_SER_ID      8'h07
`define REG_TGT_ID      8'h08
`define REG_GPO_CTL     8'h0D
`define REG_TGT_ALIAS   8'h10
`define REG_MODE_OVR    8'h1F
`define REG_PORT_SEL    8'h4C
`define REG_PASS_CTL    8'h58
`define REG_SER_ALIAS   8'h5C
`define REG_PORT_TGT    8'h65
`define REG_PORT_CFG    8'h6D
`define VAL_MODE_OVR    8'h12
`define VAL_GPO_CTL     8'h99
`define VAL_PORT0       8'h01
`define VAL_PASS_EN     8'h58
`define VAL_PORT_CFG    8'h7E
`define REG_RESET       8'h00
`define REMOTE_OUTPUT_LINE_ZERO_LOCAL_BIT  0
`define REMOTE_OUTPUT_LINE_ZERO_VAL_BIT    3
`define GPO1_LOCAL_BIT  4
`define GPO1_VAL_BIT    7
`define MODE_OVR_BIT    4
`define MODE_FAST       2'h2
`define CLK_PERIOD_NS   20
`define SCL_QUARTER_NS  100
`define SCL_QUARTER_CYC \
  ((`SCL_QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FRAME_BITS      27
`define SEQ_LEN1        3'h5
`define SEQ_LEN2        3'h6
`define APB_CTRL        8'h00
`define APB_STATUS      8'h04
`define APB_ISP         8'h08
`define CTRL_START_BIT  0
`define CTRL_VAR_BIT    1
`endif

/* hw/serdes_pkg.sv */
// Types shared by both ends of the camera link
package serdes_pkg;
  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_REG, D_DATA, D_SKIP} dev_st_t;
  typedef enum logic [1:0] {T_DES, T_SER, T_IMG} target_t;
  typedef enum logic [1:0] {L_IDLE, L_START, L_BIT, L_STOP} link_st_t;
  typedef enum logic [2:0] {H_IDLE, H_RAIL28, H_RAIL18, H_LOCK, H_ISSUE,
                            H_WAIT, H_READY, H_FAIL} host_st_t;
endpackage

/* hw/serdes_if.sv */
// Pins between the host controller and the serializer/deserializer pair
`timescale 1ns/1ps
interface serdes_if;
  logic scl;
  logic sdaHostOut;
  logic sdaHostOe;
  logic sdaDevOut;
  logic sdaDevOe;
  logic sda;
  logic lockInd;
  logic passInd;
  logic chipEnable;
  // Open-drain bus: low whenever any enabled driver pulls low
  assign sda = ~((sdaHostOe & ~sdaHostOut) | (sdaDevOe & ~sdaDevOut));
  modport host (output scl, sdaHostOut, sdaHostOe, chipEnable,
                input sda, lockInd, passInd);
  modport device (input scl, sda, chipEnable,
                  output sdaDevOut, sdaDevOe, lockInd, passInd);
endinterface

/* hw/serdes_device_end.sv */
// Serializer/deserializer pair: link status, register bank, forwarding
// Notes on behaviour
// [RQ1] Lock high once PLL locked
// [RQ2] Lock low when forward link lost
// [RQ3] Pass low on received data error
// [RQ4] Serializer answers at 7-bit 0x58
// [RQ5] Deserializer at 0x60 or 0x30 per variant
// [RQ6] Host configures deserializer before anything remote
// [RQ7] First variant: identifier 0xB0 into 0x07
// [RQ8] Serializer identifier captured automatically on lock
// [RQ9] First variant: 0x90 into 0x08 and 0x10
// [RQ10] 0x12 into 0x1F selects 12-bit fast
// [RQ11] 0x99 into 0x0D drives outputs high locally
// [RQ12] Host releases imager reset before ISP traffic
// [RQ13] Second variant: 0x01 into 0x4C opens port 0
// [RQ14] Second variant: 0x58 into 0x58 enables pass-through
// [RQ15] Second variant: serializer alias 0xB0 into 0x5C
// [RQ16] Second variant: imager identifier 0x90 into 0x65
// [RQ17] 0x7E into 0x6D selects coax, raw fast
// [RQ18] Enable released after 2.8 V then 1.8 V
// [RQ19] Remote writes forwarded to serializer-side bus
// [RQ20] Imager acknowledges only after proper initialisation
// [RQ21] Enable low keeps serializer powered down
// [RQ22] Bit mode from strap, register may override
// [RQ23] Host waits for lock before remote writes
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "serdes_params.svh"
module serdes_device_end
  import serdes_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Link toward the host
  serdes_if.device        link,
  // Local pins
  input  wire logic       secondVariant,
  input  wire logic       bitModeStrap,
  input  wire logic       pllLocked,
  input  wire logic       dataError,
  // Serializer side
  output logic            serPowered,
  output logic            remoteOutZero,
  output logic            remoteOutOne,
  output logic            twelveBitFast,
  output logic            imgWrStrobe,
  output logic [7:0]      imgReg,
  output logic [7:0]      imgData
);
  logic [5:0] syncA_reg;
  logic [5:0] syncB_reg;
  logic       sclPrev_reg;
  logic       sdaPrev_reg;
  logic       lock_reg;
  logic       pass_reg;
  logic       ackDrive_reg;
  dev_st_t    st_reg;
  target_t    tgt_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] regAddr_reg;
  logic [7:0] serId_reg;
  logic [7:0] tgtId_reg;
  logic [7:0] gpoCtl_reg;
  logic [7:0] tgtAlias_reg;
  logic [7:0] modeOvr_reg;
  logic [7:0] portSel_reg;
  logic [7:0] passCtl_reg;
  logic [7:0] serAlias_reg;
  logic [7:0] portTgt_reg;
  logic [7:0] portCfg_reg;
  logic       cfgOvr_reg;
  logic       serPowered_reg;
  logic       out0_reg;
  logic       out1_reg;
  logic       fast_reg;
  logic       imgStb_reg;
  logic [7:0] imgReg_reg;
  logic [7:0] imgData_reg;
  logic       sclS, sdaS, powered, pllS, errS, strapS;
  logic       startEv, stopEv, riseEv, fallEv, wrEn, addrOk, desReady;
  logic [6:0] desAddr, serAddr, imgAddr;
  target_t    tgtNext;

  // Every pin from the far side crosses two flops before use
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      syncA_reg <= 6'h03;
      syncB_reg <= 6'h03;
    end
    else
    begin
      syncA_reg <= {bitModeStrap, dataError, pllLocked, link.chipEnable,
                    link.sda, link.scl};
      syncB_reg <= syncA_reg;
    end
  end
  assign {strapS, errS, pllS, powered, sdaS, sclS} = syncB_reg;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end
    else
    begin
      sclPrev_reg <= sclS;
      sdaPrev_reg <= sdaS;
    end
  end
  assign startEv = sclS & sclPrev_reg & sdaPrev_reg & ~sdaS;
  assign stopEv  = sclS & sclPrev_reg & ~sdaPrev_reg & sdaS;
  assign riseEv  = sclS & ~sclPrev_reg;
  assign fallEv  = ~sclS & sclPrev_reg;

  // [RQ1] Lock follows PLL
  // [RQ2] Loss drops lock
  // [RQ3] Error drops pass
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      lock_reg <= 1'b0;
      pass_reg <= 1'b0;
    end
    else
    begin
      lock_reg <= powered & pllS;
      pass_reg <= powered & pllS & ~errS;
    end
  end

  // [RQ5] Variant address select
  assign desAddr = secondVariant ? `DES2_ADDR7 : `DES1_ADDR7;
  // [RQ13] Remote path gating
  // [RQ14] Pass-through enable
  assign desReady = ~secondVariant |
                    ((portSel_reg == `VAL_PORT0) &
                     (passCtl_reg == `VAL_PASS_EN));
  // [RQ4] Serializer address
  // [RQ15] Alias on second variant
  assign serAddr = secondVariant ? serAlias_reg[7:1] : `SER_ADDR7;
  assign imgAddr = secondVariant ? portTgt_reg[7:1] : tgtAlias_reg[7:1];

  // [RQ20] Imager needs setup
  always_comb
  begin
    tgtNext = T_DES;
    addrOk  = 1'b0;
    if (shift_reg[7:1] == desAddr)
      addrOk = 1'b1;
    else if (lock_reg & desReady & (serAddr != 7'h00) &
             (shift_reg[7:1] == serAddr))
    begin
      tgtNext = T_SER;
      addrOk  = 1'b1;
    end
    else if (lock_reg & desReady & out0_reg & (imgAddr != 7'h00) &
             (shift_reg[7:1] == imgAddr))
    begin
      tgtNext = T_IMG;
      addrOk  = 1'b1;
    end
    if (shift_reg[0])
      addrOk = 1'b0;
  end

  // Only single-register writes; reads are refused at the address byte
  always_ff @(posedge clk)
  begin
    if (sys_rst | ~powered)
    begin
      st_reg       <= D_IDLE;
      tgt_reg      <= T_DES;
      cnt_reg      <= 4'h0;
      shift_reg    <= 8'h00;
      regAddr_reg  <= 8'h00;
      ackDrive_reg <= 1'b0;
    end
    else if (startEv)
    begin
      st_reg       <= D_ADDR;
      cnt_reg      <= 4'h0;
      ackDrive_reg <= 1'b0;
    end
    else if (stopEv)
    begin
      st_reg       <= D_IDLE;
      ackDrive_reg <= 1'b0;
    end
    else if (riseEv & (st_reg != D_IDLE) & (cnt_reg < 4'h9))
    begin
      if (cnt_reg < 4'h8)
        shift_reg <= {shift_reg[6:0], sdaS};
      cnt_reg <= cnt_reg + 4'h1;
    end
    else if (fallEv & (cnt_reg == 4'h8))
    begin
      unique case (st_reg)
        D_ADDR:
        begin
          ackDrive_reg <= addrOk;
          tgt_reg      <= tgtNext;
          st_reg       <= addrOk ? D_REG : D_SKIP;
        end
        D_REG:
        begin
          ackDrive_reg <= 1'b1;
          regAddr_reg  <= shift_reg;
          st_reg       <= D_DATA;
        end
        D_DATA:
        begin
          ackDrive_reg <= 1'b1;
          st_reg       <= D_SKIP;
        end
        default:
          ackDrive_reg <= 1'b0;
      endcase
    end
    else if (fallEv & (cnt_reg == 4'h9))
    begin
      ackDrive_reg <= 1'b0;
      cnt_reg      <= 4'h0;
    end
  end
  assign wrEn = fallEv & (cnt_reg == 4'h8) & (st_reg == D_DATA);

  // [RQ21] Power-down clears all
  always_ff @(posedge clk)
  begin
    if (sys_rst | ~powered)
    begin
      serId_reg    <= `REG_RESET;
      tgtId_reg    <= `REG_RESET;
      gpoCtl_reg   <= `REG_RESET;
      tgtAlias_reg <= `REG_RESET;
      modeOvr_reg  <= `REG_RESET;
      portSel_reg  <= `REG_RESET;
      passCtl_reg  <= `REG_RESET;
      serAlias_reg <= `REG_RESET;
      portTgt_reg  <= `REG_RESET;
      portCfg_reg  <= `REG_RESET;
      cfgOvr_reg   <= 1'b0;
    end
    else
    begin
      // [RQ8] Capture on lock
      if (pllS & ~lock_reg)
        serId_reg <= `SER_ID_VAL;
      // [RQ7] Deserializer register writes
      // [RQ9] Target and alias
      if (wrEn & (tgt_reg == T_DES))
      begin
        case (regAddr_reg)
          `REG_SER_ID:    serId_reg <= shift_reg;
          `REG_TGT_ID:    tgtId_reg <= shift_reg;
          `REG_TGT_ALIAS: tgtAlias_reg <= shift_reg;
          `REG_MODE_OVR:  modeOvr_reg <= shift_reg;
          `REG_PORT_SEL:  portSel_reg <= shift_reg;
          `REG_PASS_CTL:  passCtl_reg <= shift_reg;
          `REG_SER_ALIAS: serAlias_reg <= shift_reg;
          `REG_PORT_TGT:  portTgt_reg <= shift_reg;
          `REG_PORT_CFG:
          begin
            portCfg_reg <= shift_reg;
            cfgOvr_reg  <= 1'b1;
          end
          default:        ;
        endcase
      end
      // [RQ11] Output control register
      if (wrEn & (tgt_reg == T_SER) & (regAddr_reg == `REG_GPO_CTL))
        gpoCtl_reg <= shift_reg;
    end
  end

  // Remote drive of the outputs is not modelled, so unset local bits read 0
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      serPowered_reg <= 1'b0;
      out0_reg       <= 1'b0;
      out1_reg       <= 1'b0;
      fast_reg       <= 1'b0;
    end
    else
    begin
      serPowered_reg <= powered;
      // [RQ11] Local outputs high
      out0_reg <= gpoCtl_reg[`REMOTE_OUTPUT_LINE_ZERO_LOCAL_BIT] & gpoCtl_reg[`REMOTE_OUTPUT_LINE_ZERO_VAL_BIT];
      out1_reg <= gpoCtl_reg[`GPO1_LOCAL_BIT] & gpoCtl_reg[`GPO1_VAL_BIT];
      // [RQ22] Strap unless overridden
      // [RQ10] Override to fast
      // [RQ17] Port format fast
      if (cfgOvr_reg)
        fast_reg <= portCfg_reg[1:0] == `MODE_FAST;
      else if (modeOvr_reg[`MODE_OVR_BIT])
        fast_reg <= modeOvr_reg[1:0] == `MODE_FAST;
      else
        fast_reg <= strapS;
    end
  end

  // [RQ19] Forward imager write
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      imgStb_reg  <= 1'b0;
      imgReg_reg  <= 8'h00;
      imgData_reg <= 8'h00;
    end
    else
    begin
      imgStb_reg <= wrEn & (tgt_reg == T_IMG);
      if (wrEn & (tgt_reg == T_IMG))
      begin
        imgReg_reg  <= regAddr_reg;
        imgData_reg <= shift_reg;
      end
    end
  end

  assign link.sdaDevOut = 1'b0;
  assign link.sdaDevOe  = ackDrive_reg;
  assign link.lockInd   = lock_reg;
  assign link.passInd   = pass_reg;
  assign serPowered     = serPowered_reg;
  assign remoteOutZero  = out0_reg;
  assign remoteOutOne   = out1_reg;
  assign twelveBitFast  = fast_reg;
  assign imgWrStrobe    = imgStb_reg;
  assign imgReg         = imgReg_reg;
  assign imgData        = imgData_reg;
endmodule

/* hw/serdes_host_end.sv */
// Host bring-up controller: power order, lock wait, write sequence
`timescale 1ns/1ps
`include "serdes_params.svh"
module serdes_host_end
  import serdes_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Rail status pins
  input  wire logic        rail28Good,
  input  wire logic        rail18Good,
  // Link toward the pair
  serdes_if.host           link
);
  localparam logic [2:0] QTR = 3'(`SCL_QUARTER_CYC - 1);
  logic [3:0]  syncA_reg;
  logic [3:0]  syncB_reg;
  logic        r28S, r18S, lockS, sdaS;
  logic        pready_reg, pslverr_reg, variant_reg;
  logic [31:0] prdata_reg;
  logic        acc, fin, startWr, ispWr, tick, engGo, ackSlot;
  host_st_t    hst_reg;
  logic [2:0]  idx_reg;
  logic        ispPend_reg, ispOp_reg, enable_reg;
  logic [15:0] ispCmd_reg;
  logic [22:0] word;
  link_st_t    lst_reg;
  logic [1:0]  ph_reg;
  logic [2:0]  q_reg;
  logic [4:0]  bit_reg;
  logic [26:0] frame_reg;
  logic        scl_reg, sdaLow_reg, nack_reg, engDone_reg;

  // Fixed bring-up table: {7-bit address, register, value}
  // [RQ6] Deserializer first
  function automatic logic [22:0] seqWord(input logic v2,
                                          input logic [2:0] i);
    logic [22:0] w;
    w = {`SER_ADDR7, `REG_GPO_CTL, `VAL_GPO_CTL};
    if (!v2)
      case (i)
        3'h0: w = {`DES1_ADDR7, `REG_SER_ID, `SER_ID_VAL};
        3'h1: w = {`DES1_ADDR7, `REG_TGT_ID, `IMG_ID_VAL};
        3'h2: w = {`DES1_ADDR7, `REG_TGT_ALIAS, `IMG_ID_VAL};
        3'h3: w = {`DES1_ADDR7, `REG_MODE_OVR, `VAL_MODE_OVR};
        default: ;
      endcase
    else
      case (i)
        3'h0: w = {`DES2_ADDR7, `REG_PORT_SEL, `VAL_PORT0};
        3'h1: w = {`DES2_ADDR7, `REG_PASS_CTL, `VAL_PASS_EN};
        3'h2: w = {`DES2_ADDR7, `REG_SER_ALIAS, `SER_ID_VAL};
        // [RQ16] Imager identifier
        3'h3: w = {`DES2_ADDR7, `REG_PORT_TGT, `IMG_ID_VAL};
        3'h4: w = {`DES2_ADDR7, `REG_PORT_CFG, `VAL_PORT_CFG};
        default: ;
      endcase
    return w;
  endfunction

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      syncA_reg <= 4'h1;
      syncB_reg <= 4'h1;
    end
    else
    begin
      syncA_reg <= {rail28Good, rail18Good, link.lockInd, link.sda};
      syncB_reg <= syncA_reg;
    end
  end
  assign {r28S, r18S, lockS, sdaS} = syncB_reg;

  // Answer one cycle after the first access cycle; writes land only at
  // the edge that sees pready, so a stalled master never half-commits
  assign acc     = psel & penable & ~pready_reg;
  assign fin     = psel & penable & pready_reg & pwrite;
  assign startWr = fin & (paddr == `APB_CTRL) & pwdata[`CTRL_START_BIT];
  assign ispWr   = fin & (paddr == `APB_ISP);
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
      variant_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= acc;
      pslverr_reg <= acc & (paddr != `APB_CTRL) &
                     (paddr != `APB_STATUS) & (paddr != `APB_ISP);
      if (fin & (paddr == `APB_CTRL))
        variant_reg <= pwdata[`CTRL_VAR_BIT];
      if (acc & ~pwrite)
        case (paddr)
          `APB_CTRL:   prdata_reg <= {30'h0, variant_reg, 1'b0};
          `APB_STATUS: prdata_reg <= {26'h0, link.passInd, enable_reg,
                                      lockS, hst_reg == H_FAIL,
                                      hst_reg == H_READY, ispPend_reg};
          `APB_ISP:    prdata_reg <= {16'h0, ispCmd_reg};
          default:     prdata_reg <= 32'h0;
        endcase
    end
  end

  assign word = ispOp_reg ? {7'(`IMG_ID_VAL >> 1), ispCmd_reg}
                          : seqWord(variant_reg, idx_reg);
  assign engGo = hst_reg == H_ISSUE;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      hst_reg     <= H_IDLE;
      idx_reg     <= 3'h0;
      enable_reg  <= 1'b0;
      ispPend_reg <= 1'b0;
      ispOp_reg   <= 1'b0;
      ispCmd_reg  <= 16'h0;
    end
    else
    begin
      // New command wins over the clear on issue
      if (ispWr)
      begin
        ispPend_reg <= 1'b1;
        ispCmd_reg  <= pwdata[15:0];
      end
      unique case (hst_reg)
        H_IDLE, H_FAIL:
          if (startWr)
          begin
            enable_reg <= 1'b0;
            idx_reg    <= 3'h0;
            hst_reg    <= H_RAIL28;
          end
        // [RQ18] Rails in order
        H_RAIL28:
          if (r28S)
            hst_reg <= H_RAIL18;
        H_RAIL18:
          if (r18S)
          begin
            enable_reg <= 1'b1;
            hst_reg    <= H_LOCK;
          end
        // [RQ23] Wait for lock
        H_LOCK:
          if (lockS)
            hst_reg <= H_ISSUE;
        H_ISSUE:
          hst_reg <= H_WAIT;
        H_WAIT:
          if (engDone_reg)
          begin
            if (nack_reg)
              hst_reg <= H_FAIL;
            else if (ispOp_reg)
              hst_reg <= H_READY;
            // [RQ12] Reset release last
            else if (idx_reg == (variant_reg ? `SEQ_LEN2 : `SEQ_LEN1)
                                - 3'h1)
              hst_reg <= H_READY;
            else
            begin
              idx_reg <= idx_reg + 3'h1;
              hst_reg <= H_ISSUE;
            end
          end
        H_READY:
        begin
          ispOp_reg <= 1'b0;
          if (ispPend_reg & ~ispWr)
          begin
            ispPend_reg <= 1'b0;
            ispOp_reg   <= 1'b1;
            hst_reg     <= H_ISSUE;
          end
        end
      endcase
    end
  end

  // Bus clock is made here: four quarters per bit
  assign tick    = q_reg == QTR;
  assign ackSlot = (bit_reg == 5'h08) | (bit_reg == 5'h11) |
                   (bit_reg == 5'h1A);
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      lst_reg     <= L_IDLE;
      ph_reg      <= 2'h0;
      q_reg       <= 3'h0;
      bit_reg     <= 5'h0;
      frame_reg   <= 27'h0;
      scl_reg     <= 1'b1;
      sdaLow_reg  <= 1'b0;
      nack_reg    <= 1'b0;
      engDone_reg <= 1'b0;
    end
    else
    begin
      engDone_reg <= 1'b0;
      if (lst_reg == L_IDLE)
      begin
        if (engGo)
        begin
          // [RQ4] Address with write bit
          frame_reg <= {word[22:16], 1'b0, 1'b1, word[15:8], 1'b1,
                        word[7:0], 1'b1};
          bit_reg   <= 5'h0;
          ph_reg    <= 2'h0;
          q_reg     <= 3'h0;
          nack_reg  <= 1'b0;
          lst_reg   <= L_START;
        end
      end
      else
      begin
        q_reg <= tick ? 3'h0 : q_reg + 3'h1;
        if (tick)
        begin
          ph_reg <= ph_reg + 2'h1;
          unique case (lst_reg)
            L_START:
              if (ph_reg == 2'h0)
                sdaLow_reg <= 1'b1;
              else if (ph_reg == 2'h3)
              begin
                scl_reg <= 1'b0;
                lst_reg <= L_BIT;
              end
            L_BIT:
              unique case (ph_reg)
                2'h0: sdaLow_reg <= ~frame_reg[26];
                2'h1: scl_reg <= 1'b1;
                2'h2: if (ackSlot & sdaS) nack_reg <= 1'b1;
                2'h3:
                begin
                  scl_reg   <= 1'b0;
                  frame_reg <= {frame_reg[25:0], 1'b1};
                  bit_reg   <= bit_reg + 5'h1;
                  if (bit_reg == 5'(`FRAME_BITS - 1))
                    lst_reg <= L_STOP;
                end
              endcase
            default:
              unique case (ph_reg)
                2'h0: sdaLow_reg <= 1'b1;
                2'h1: scl_reg <= 1'b1;
                2'h2: sdaLow_reg <= 1'b0;
                2'h3:
                begin
                  lst_reg     <= L_IDLE;
                  engDone_reg <= 1'b1;
                end
              endcase
          endcase
        end
      end
    end
  end

  assign link.scl        = scl_reg;
  assign link.sdaHostOut = 1'b0;
  assign link.sdaHostOe  = sdaLow_reg;
  assign link.chipEnable = enable_reg;
  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
endmodule

/* sim/serdes_link_monitor.sv */
// Checks on the link pins between host and device ends
`timescale 1ns/1ps
module serdes_link_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link pins
  input wire logic scl,
  input wire logic sdaHostOut,
  input wire logic sdaHostOe,
  input wire logic sdaDevOut,
  input wire logic sdaDevOe,
  input wire logic sda,
  input wire logic lockInd,
  input wire logic passInd,
  input wire logic chipEnable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Each bus clock phase spans two quarters, so eight cycles is a floor
  sequence s_level(logic v);
    (scl == v) [*8];
  endsequence
  sequence s_ackWin;
    ##[1:12] $rose(scl) ##1 scl [*7];
  endsequence
  property p_sclHigh;
    $rose(scl) |-> s_level(1'b1);
  endproperty
  a_sclHigh: assert property (p_sclHigh)
    else $error("bus clock high phase too short");
  property p_sclLow;
    $fell(scl) |-> s_level(1'b0);
  endproperty
  a_sclLow: assert property (p_sclLow)
    else $error("bus clock low phase too short");
  property p_openDrain;
    !(sdaHostOe && sdaHostOut) && !(sdaDevOe && sdaDevOut);
  endproperty
  a_openDrain: assert property (p_openDrain)
    else $error("data line driven high");
  property p_devEdge;
    $changed(sdaDevOe) |-> !scl;
  endproperty
  a_devEdge: assert property (p_devEdge)
    else $error("device moved data while clock high");
  // Acknowledge must hold through the first eight cycles of the high phase that samples it
  property p_ackHeld;
    $rose(sdaDevOe) |-> sdaDevOe throughout s_ackWin;
  endproperty
  a_ackHeld: assert property (p_ackHeld)
    else $error("acknowledge released early");
  property p_lockOff;
    !chipEnable [*6] |-> !lockInd && !passInd;
  endproperty
  a_lockOff: assert property (p_lockOff)
    else $error("status high while powered down");
  property p_passLock;
    passInd |-> lockInd || $past(lockInd) || $past(lockInd, 2);
  endproperty
  a_passLock: assert property (p_passLock)
    else $error("pass high without lock");
  property p_startLock;
    $rose(sdaHostOe) && scl |-> chipEnable && lockInd;
  endproperty
  a_startLock: assert property (p_startLock)
    else $error("transfer started without lock");
endmodule

/* sim/tb_serdes_link_init_sequencer.sv */
// Bench: host controller and device pair joined over the link
`timescale 1ns/1ps
`include "serdes_params.svh"
module tb_serdes_link_init_sequencer;
  logic        clk;
  logic        sys_rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rail28;
  logic        rail18;
  logic        variant;
  logic        pll;
  logic        dataError;
  logic        strap;
  logic        serPowered;
  logic        outZero;
  logic        outOne;
  logic        fast;
  logic        strobe;
  logic [7:0]  imgReg;
  logic [7:0]  imgData;
  logic [31:0] rd;
  logic        err;
  int          numErrors;
  int          testsRun;
  int          strobes;
  int          cyc;
  serdes_if lnk();
  serdes_host_end i_serdes_host_end (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rail28Good(rail28), .rail18Good(rail18), .link(lnk));
  serdes_device_end i_serdes_device_end (.clk(clk), .sys_rst(sys_rst),
    .link(lnk), .secondVariant(variant), .bitModeStrap(strap),
    .pllLocked(pll), .dataError(dataError), .serPowered(serPowered),
    .remoteOutZero(outZero), .remoteOutOne(outOne), .twelveBitFast(fast),
    .imgWrStrobe(strobe), .imgReg(imgReg), .imgData(imgData));
  serdes_link_monitor i_serdes_link_monitor (.clk(clk), .sys_rst(sys_rst),
    .scl(lnk.scl), .sdaHostOut(lnk.sdaHostOut), .sdaHostOe(lnk.sdaHostOe),
    .sdaDevOut(lnk.sdaDevOut), .sdaDevOe(lnk.sdaDevOe), .sda(lnk.sda),
    .lockInd(lnk.lockInd), .passInd(lnk.passInd),
    .chipEnable(lnk.chipEnable));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (strobe === 1'b1)
      strobes <= strobes + 1;
    if (cyc == 60000)
    begin
      numErrors++;
      give_verdict;
    end
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      numErrors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until the edge that sees pready high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the global cycle limit ends a wait that never sees pready
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int k;
    k = 0;
    do
    begin
      apb(1'b0, `APB_STATUS, 32'h0);
      k++;
    end
    while ((rd & m) !== v && k < 1500);
    chk(rd & m, v);
  endtask
  task automatic isp(input logic [15:0] c);
    int n0;
    int k;
    n0 = strobes;
    k = 0;
    apb(1'b1, `APB_ISP, {16'h0, c});
    while (strobes == n0 && k < 3000)
    begin
      @(posedge clk);
      k++;
    end
    chk({16'h0, imgReg, imgData}, {16'h0, c});
    poll(32'h5, 32'h0);
  endtask
  task automatic rstPulse;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  initial
  begin
    {sys_rst, psel, penable, pwrite, rail28, rail18} = 6'h20;
    {variant, pll, dataError, paddr, pwdata} = 43'h0;
    strap = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    chk({30'h0, lnk.scl, lnk.chipEnable}, 32'h2);
    apb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, `APB_CTRL, 32'h1);
    rail18 <= 1'b1;
    repeat (30) @(posedge clk);
    poll(32'h10, 32'h0);
    rail28 <= 1'b1;
    poll(32'h18, 32'h10);
    // Synchroniser and output flop lag behind the status read
    repeat (4) @(posedge clk);
    chk({31'h0, serPowered}, 32'h1);
    chk({31'h0, fast}, 32'h1);
    strap <= 1'b0;
    pll <= 1'b1;
    poll(32'h0E, 32'h0A);
    chk({29'h0, outZero, outOne, fast}, 32'h7);
    isp(16'h3AC5);
    dataError <= 1'b1;
    poll(32'h28, 32'h08);
    dataError <= 1'b0;
    poll(32'h28, 32'h28);
    pll <= 1'b0;
    poll(32'h28, 32'h0);
    rstPulse();
    variant <= 1'b1;
    pll <= 1'b1;
    apb(1'b1, `APB_CTRL, 32'h3);
    poll(32'h6, 32'h2);
    chk({29'h0, outZero, outOne, fast}, 32'h7);
    isp(16'h5CA3);
    rstPulse();
    variant <= 1'b0;
    apb(1'b1, `APB_CTRL, 32'h3);
    poll(32'h6, 32'h4);
    give_verdict();
  end
endmodule
